// *** core/cr2_ctrl_reg.sv ***
// Upper 18 bits of the control-function-two register and the logic it steers.
// Assumes a serial I/O port decoder outside presents whole-word accesses,
// and that lower bits and tuning words are supplied by neighbouring blocks.
`timescale 1ns/100ps
`include "cr2_map.svh"
module cr2_ctrl_reg #(
  parameter int unsigned UPD_PERIOD = `CR2_UPD_PERIOD
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [13:0] control_function_two_low_i,
  input wire logic [31:0] ftw_stored_i,
  input wire logic [31:0] ftw_live_i,
  input wire cr2_pkg::cr2_opmode_t op_mode_i,
  input wire logic osk_en_i,
  input wire logic [17:0] data_pin_i,
  input wire logic io_update_i,
  output logic io_update_o,
  output logic io_update_oe_o,
  output logic update_pulse_o,
  output logic sync_clk_o,
  output logic par_port_en_o,
  output logic dual_serial_en_o,
  output logic [17:0] par_data_o,
  output logic [1:0] serial_data_o,
  output logic [15:0] gpio_data_o,
  output logic serial_lsb_first_o,
  output logic early_fsync_o,
  output logic asf_bypass_o,
  output logic asf_from_profile_o
);
  import cr2_pkg::*;

  logic [31:0] buf_q;
  logic [31:0] act_q;
  logic int_upd_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic upd_pin_prev_q;
  logic [1:0] div_q;
  logic sync_clk_q;
  logic [0:0] upd_pin_lvl;
  logic [17:0] data_lvl;
  logic [31:0] rd_mux;
  logic [17:0] par_q;
  logic [1:0] ser_q;
  logic [15:0] gpio_q;
  logic par_en_q;
  logic ser_en_q;
  logic lsb_q;
  logic early_q;
  logic bypass_q;
  logic prof_q;
  logic int_pulse;
  logic int_pulse_q;

  wire wr_ctrl = reg_wr_i && (reg_addr_i == `CR2_ADDR_CTRL_TWO);
  wire rd_ctrl = (reg_addr_i == `CR2_ADDR_CTRL_TWO);
  wire rd_ftw = (reg_addr_i == `CR2_ADDR_FTW);
  wire [31:0] wr_masked = reg_wdata_i & `CR2_UPPER_MASK;

  // Update pin level uses the same filtered path as the data pins
  cr2_pin_sync #(
    .WIDTH(1)
  ) u_upd_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(io_update_i),
    .level_o(upd_pin_lvl)
  );

  cr2_pin_sync #(
    .WIDTH(18)
  ) u_data_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(data_pin_i),
    .level_o(data_lvl)
  );

  cr2_upd_timer #(
    .PERIOD(UPD_PERIOD)
  ) u_timer (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .en_i(int_upd_q),
    .prescale_i(cr2_prescale_t'(act_q[`CR2_PRESCALE_HI:`CR2_PRESCALE_LO])),
    .pulse_o(int_pulse)
  );

  // Update source: external rising edge, or internal timer
  wire ext_rise = upd_pin_lvl[0] && !upd_pin_prev_q;
  wire upd_evt = int_upd_q ? int_pulse : ext_rise;

  // Mode decode
  wire quad_mode = (op_mode_i == CR2_MODE_QUAD);
  wire ser_sel = act_q[`CR2_BIT_SER_SEL] && quad_mode;
  wire tone_no_osk = (op_mode_i == CR2_MODE_TONE) && !osk_en_i;
  wire prof_src = tone_no_osk && act_q[`CR2_BIT_ASF_PROF];
  wire unity = tone_no_osk && !act_q[`CR2_BIT_ASF_PROF];
  wire [15:0] gpio_view = {data_lvl[17:6], data_lvl[3:0]};
  // Bit 23 reads back its live value, not the active copy
  wire [31:0] live_word = {act_q[31:24], int_upd_q, act_q[22:0]};
  wire [31:0] ctrl_view = (live_word & `CR2_UPPER_MASK) | {18'h0_0000, control_function_two_low_i};
  wire [31:0] ftw_view = act_q[`CR2_BIT_LIVE_FTW] ? ftw_live_i : ftw_stored_i;

  // Read selection; unmapped addresses read zero
  always_comb
  begin
    if (rd_ctrl)
      rd_mux = ctrl_view;
    else if (rd_ftw)
      rd_mux = ftw_view;
    else
      rd_mux = 32'h0000_0000;
  end

  // Next values of the registered outputs
  wire [31:0] act_d = wr_ctrl ? wr_masked : buf_q;
  wire sync_clk_d = act_q[`CR2_BIT_SYNC_CLK] ? div_q[1] : 1'b0;
  wire int_pulse_d = int_upd_q && int_pulse;
  wire [17:0] par_d = ser_sel ? 18'h0_0000 : data_lvl;
  wire [1:0] ser_d = ser_sel ? data_lvl[5:4] : 2'h0;
  wire [15:0] gpio_d = ser_sel ? gpio_view : 16'h0000;
  wire lsb_d = ser_sel && act_q[`CR2_BIT_LSB_FIRST];
  wire early_d = ser_sel && act_q[`CR2_BIT_EARLY_FS];

  // Buffer takes every write; active copy waits for an update
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      buf_q <= `CR2_RESET;
    else if (wr_ctrl)
      buf_q <= wr_masked;
  end

  // A write in the update cycle goes straight through and is not lost
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      act_q <= `CR2_RESET;
    else if (upd_evt)
      act_q <= act_d;
  end

  // Bit 23 bypasses the update, else the pin could never turn around
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      int_upd_q <= 1'b0;
    else if (wr_ctrl)
      int_upd_q <= reg_wdata_i[`CR2_BIT_INT_UPD];
  end

  // Resets low like the idle pin, so no false edge follows reset
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      upd_pin_prev_q <= 1'b0;
    else
      upd_pin_prev_q <= upd_pin_lvl[0];
  end

  // Read strobe answered on the next edge
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= reg_rd_i;
  end

  // Read word holds until the next read
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_q <= 32'h0000_0000;
    else if (reg_rd_i)
      rdata_q <= rd_mux;
  end

  // Divider runs free so the sync clock phase never jumps
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end

  // Quarter-rate sync clock; held low when disabled
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sync_clk_q <= 1'b0;
    else
      sync_clk_q <= sync_clk_d;
  end

  // Internal update driven out on the pin for one cycle
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      int_pulse_q <= 1'b0;
    else
      int_pulse_q <= int_pulse_d;
  end

  // Data pin routing, registered; parallel port is the reset mode
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      par_en_q <= 1'b1;
    else
      par_en_q <= !ser_sel;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ser_en_q <= 1'b0;
    else
      ser_en_q <= ser_sel;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      par_q <= 18'h0_0000;
    else
      par_q <= par_d;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ser_q <= 2'h0;
    else
      ser_q <= ser_d;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      gpio_q <= 16'h0000;
    else
      gpio_q <= gpio_d;
  end

  // Serial port options, forced low outside serial mode
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lsb_q <= 1'b0;
    else
      lsb_q <= lsb_d;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      early_q <= 1'b0;
    else
      early_q <= early_d;
  end

  // Amplitude source, only in single tone with keying off
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      bypass_q <= 1'b0;
    else
      bypass_q <= unity;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      prof_q <= 1'b0;
    else
      prof_q <= prof_src;
  end

  // Pin direction follows bit 23 at once
  assign io_update_oe_o = int_upd_q;
  assign io_update_o = int_pulse_q;
  assign update_pulse_o = upd_evt;
  assign sync_clk_o = sync_clk_q;
  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign par_port_en_o = par_en_q;
  assign dual_serial_en_o = ser_en_q;
  assign par_data_o = par_q;
  assign serial_data_o = ser_q;
  assign gpio_data_o = gpio_q;
  assign serial_lsb_first_o = lsb_q;
  assign early_fsync_o = early_q;
  assign asf_bypass_o = bypass_q;
  assign asf_from_profile_o = prof_q;
endmodule : cr2_ctrl_reg

// *** pkg/cr2_map.svh ***
// Constants for the upper control-function-two register bank.
// Assumes the serial I/O port presents register accesses by printed address.
`ifndef CR2_MAP_SVH
`define CR2_MAP_SVH
`define CR2_ADDR_CTRL_TWO 8'h01
`define CR2_ADDR_FTW 8'h07
`define CR2_BIT_SER_SEL 31
`define CR2_BIT_LSB_FIRST 30
`define CR2_BIT_EARLY_FS 29
`define CR2_BIT_ASF_PROF 24
`define CR2_BIT_INT_UPD 23
`define CR2_BIT_SYNC_CLK 22
`define CR2_BIT_LIVE_FTW 16
`define CR2_PRESCALE_HI 15
`define CR2_PRESCALE_LO 14
`define CR2_UPPER_MASK 32'hE1C1_C000
`define CR2_RESET 32'h0040_0000
`define CR2_SYNC_DIV 4
`define CR2_UPD_PERIOD 16
`endif

// *** pkg/cr2_pkg.sv ***
// Types shared by the control-function-two bank.
// Assumes nothing beyond the map header.
package cr2_pkg;
  typedef enum logic [1:0] {
    CR2_MODE_QUAD = 2'h0,
    CR2_MODE_TONE = 2'h1,
    CR2_MODE_INTERP = 2'h2,
    CR2_MODE_RSVD = 2'h3
  } cr2_opmode_t;
  typedef enum logic [1:0] {
    CR2_DIV1 = 2'h0,
    CR2_DIV2 = 2'h1,
    CR2_DIV4 = 2'h2,
    CR2_DIV8 = 2'h3
  } cr2_prescale_t;
endpackage : cr2_pkg

// *** core/cr2_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter, one per bit.
// Assumes pins are asynchronous to mclk_i.
`timescale 1ns/100ps
module cr2_pin_sync #(
  parameter int unsigned WIDTH = 18
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  import cr2_pkg::*;
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge mclk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          lvl_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= pin_i[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          // Change counts only once two stages agree
          if (s2_q[g] == s3_q[g])
            lvl_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate
  assign level_o = lvl_q;
endmodule : cr2_pin_sync

// *** core/cr2_upd_timer.sv ***
// Internal update timer with selectable prescaler.
// Assumes en_i drops whenever external update is in use.
`timescale 1ns/100ps
`include "cr2_map.svh"
module cr2_upd_timer #(
  parameter int unsigned PERIOD = `CR2_UPD_PERIOD
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire cr2_pkg::cr2_prescale_t prescale_i,
  output logic pulse_o
);
  import cr2_pkg::*;
  localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  logic [2:0] pre_q;
  logic [2:0] pre_top;
  logic [CW-1:0] cnt_q;
  logic tick;
  logic wrap;
  logic pulse_q;
  // Divide by 1, 2, 4 or 8
  assign pre_top = (prescale_i == CR2_DIV1) ? 3'h0 :
                   (prescale_i == CR2_DIV2) ? 3'h1 :
                   (prescale_i == CR2_DIV4) ? 3'h3 : 3'h7;
  assign tick = en_i && (pre_q >= pre_top);
  assign wrap = tick && (cnt_q == CW'(PERIOD - 1));
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pre_q <= 3'h0;
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end
    else
    begin
      // Idle while external update is selected
      pre_q <= (!en_i || tick) ? 3'h0 : pre_q + 3'h1;
      cnt_q <= (!en_i || wrap) ? '0 : (tick ? cnt_q + CW'(1) : cnt_q);
      pulse_q <= wrap;
    end
  end
  assign pulse_o = pulse_q;
endmodule : cr2_upd_timer

// *** testbench/cr2_ctrl_reg_sva.sv ***
// Checker for the control-function-two bank outputs.
// Assumes it is bound onto cr2_ctrl_reg and sees its ports only.
`timescale 1ns/100ps
module cr2_ctrl_reg_sva
  import cr2_pkg::*;
#(
  parameter int unsigned UPD_PERIOD = 16
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire cr2_pkg::cr2_opmode_t op_mode_i,
  input wire logic par_port_en_o,
  input wire logic dual_serial_en_o,
  input wire logic serial_lsb_first_o,
  input wire logic early_fsync_o,
  input wire logic asf_bypass_o,
  input wire logic asf_from_profile_o,
  input wire logic io_update_oe_o,
  input wire logic io_update_o,
  input wire logic sync_clk_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_pulse;
    io_update_o ##1 !io_update_o;
  endsequence
  property p_port; par_port_en_o == !dual_serial_en_o; endproperty
  property p_quad; dual_serial_en_o |-> $past(op_mode_i) == CR2_MODE_QUAD; endproperty
  property p_lsb; serial_lsb_first_o |-> dual_serial_en_o; endproperty
  property p_early; early_fsync_o |-> dual_serial_en_o; endproperty
  property p_asf; asf_from_profile_o |-> !asf_bypass_o && $past(op_mode_i) == CR2_MODE_TONE; endproperty
  property p_oe; reg_wr_i && reg_addr_i == 8'h01 |=> io_update_oe_o == $past(reg_wdata_i[23]); endproperty
  // Rise only after two low cycles keeps the quarter rate
  property p_sync; $rose(sync_clk_o) |-> $past(sync_clk_o, 2) == 1'b0; endproperty
  property p_ioupd; io_update_o |-> io_update_oe_o ##0 s_pulse; endproperty
  a_port: assert property (p_port) else $error("port mode flags disagree");
  a_quad: assert property (p_quad) else $error("serial port outside quad mode");
  a_lsb: assert property (p_lsb) else $error("bit order without serial port");
  a_early: assert property (p_early) else $error("frame sync without serial port");
  a_asf: assert property (p_asf) else $error("profile scale outside single tone");
  a_oe: assert property (p_oe) else $error("update pin direction late");
  a_sync: assert property (p_sync) else $error("sync clock too fast");
  a_ioupd: assert property (p_ioupd) else $error("update pulse bad");
endmodule : cr2_ctrl_reg_sva
bind cr2_ctrl_reg cr2_ctrl_reg_sva #(.UPD_PERIOD(UPD_PERIOD)) cr2_ctrl_reg_sva_i (.mclk_i(mclk_i),
  .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .op_mode_i(op_mode_i), .par_port_en_o(par_port_en_o), .dual_serial_en_o(dual_serial_en_o),
  .serial_lsb_first_o(serial_lsb_first_o), .early_fsync_o(early_fsync_o), .asf_bypass_o(asf_bypass_o),
  .asf_from_profile_o(asf_from_profile_o), .io_update_oe_o(io_update_oe_o), .io_update_o(io_update_o),
  .sync_clk_o(sync_clk_o));

// *** testbench/cr2_host_model.sv ***
// Host side: update pin driver and data pin values.
// Assumes pulse_update is called from the testbench after a falling edge.
`timescale 1ns/100ps
module cr2_host_model (
  input wire logic mclk_i,
  input wire logic pin_oe_i,
  input wire logic pin_dev_i,
  output wire logic upd_pin_o,
  output logic [17:0] data_pin_o
);
  logic drv_q = 1'b0;
  initial data_pin_o = 18'h2AB5C;
  // Wire level from both parties; host drives only while device listens
  assign upd_pin_o = pin_oe_i ? pin_dev_i : drv_q;
  task pulse_update();
    @(negedge mclk_i);
    drv_q = !pin_oe_i;
    repeat (4) @(negedge mclk_i);
    drv_q = 1'b0;
  endtask : pulse_update
endmodule : cr2_host_model

// *** testbench/control_register_two_upper_tb.sv ***
// Self-checking bench for the control-function-two bank.
// Assumes the host model supplies pins and the update pin.
`timescale 1ns/100ps
module control_register_two_upper_tb;
  import cr2_pkg::*;
  localparam int unsigned UPD = 4;
  localparam logic [13:0] LOW = 14'h1ABC;
  localparam logic [31:0] FTW_S = 32'h1111_2222;
  localparam logic [31:0] FTW_L = 32'hA5A5_0F0F;
  logic mclk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, output_shift_keying = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic rvalid, upd_o, upd_oe, sclk, par_en, ser_en, lsb, early, byp, prof, upd_pin, upd_ev;
  logic [17:0] pins, par_d;
  logic [1:0] ser_d;
  logic [15:0] gpio;
  cr2_opmode_t mode = CR2_MODE_QUAD;
  int err_total = 0, checked = 0, n, k, n_evt = 0;
  always #50 mclk = !mclk;
  // Update events counted at the falling edge, where the pulse has settled
  always @(negedge mclk) n_evt += (upd_ev === 1'b1);
  cr2_ctrl_reg #(.UPD_PERIOD(UPD)) cr2_ctrl_reg_i (.mclk_i(mclk), .rst_b_i(rst_b), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .control_function_two_low_i(LOW),
    .ftw_stored_i(FTW_S), .ftw_live_i(FTW_L), .op_mode_i(mode), .osk_en_i(output_shift_keying), .data_pin_i(pins),
    .io_update_i(upd_pin), .io_update_o(upd_o), .io_update_oe_o(upd_oe), .update_pulse_o(upd_ev),
    .sync_clk_o(sclk), .par_port_en_o(par_en), .dual_serial_en_o(ser_en), .par_data_o(par_d),
    .serial_data_o(ser_d), .gpio_data_o(gpio), .serial_lsb_first_o(lsb), .early_fsync_o(early),
    .asf_bypass_o(byp), .asf_from_profile_o(prof));
  cr2_host_model cr2_host_model_i (.mclk_i(mclk), .pin_oe_i(upd_oe), .pin_dev_i(upd_o), .upd_pin_o(upd_pin),
    .data_pin_o(pins));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk);
    wr = 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge mclk);
    rd = 1'b1;
    addr = a;
    @(negedge mclk);
    rd = 1'b0;
    chk({31'h0, rvalid}, 32'h0000_0001);
    chk(rdata, exp);
  endtask : rd_chk
  // Counts cycles between two timer pulses, bounded so a dead timer cannot hang
  task upd_gap();
    k = 0;
    while (upd_o !== 1'b1 && k < 300)
    begin
      @(negedge mclk);
      k++;
    end
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (upd_o !== 1'b1 && n < 300);
  endtask : upd_gap
  task test_done();
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (6) @(negedge mclk);
    chk({13'h0, par_en, par_d}, {13'h0, 1'b1, pins});
    rd_chk(8'h01, 32'h0040_0000 | LOW);
    k = 0;
    repeat (8)
    begin
      @(negedge mclk);
      k += (sclk === 1'b1);
    end
    chk(32'(k), 32'h0000_0004);
    rd_chk(8'h07, FTW_S);
    rd_chk(8'h33, 32'h0000_0000);
    wr_reg(8'h01, 32'hFF7F_FFFF);
    rd_chk(8'h01, 32'h0040_0000 | LOW);
    chk({31'h0, upd_oe}, 32'h0000_0000);
    chk(32'(n_evt), 32'h0000_0000);
    cr2_host_model_i.pulse_update();
    repeat (8) @(negedge mclk);
    chk(32'(n_evt), 32'h0000_0001);
    rd_chk(8'h01, 32'hE141_C000 | LOW);
    chk({gpio, 14'h0, ser_d}, {pins[17:6], pins[3:0], 14'h0, pins[5:4]});
    chk({28'h0, ser_en, par_en, lsb, early}, 32'h0000_000B);
    rd_chk(8'h07, FTW_L);
    mode = CR2_MODE_TONE;
    repeat (3) @(negedge mclk);
    chk({28'h0, ser_en, par_en, lsb, prof}, 32'h0000_0005);
    output_shift_keying = 1'b1;
    repeat (3) @(negedge mclk);
    chk({30'h0, byp, prof}, 32'h0000_0000);
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'h01, 32'h0080_0000 | (32'(c) << 14));
      chk({31'h0, upd_oe}, 32'h0000_0001);
      repeat (3) upd_gap();
      chk(32'(n), 32'(UPD << c));
    end
    rd_chk(8'h01, 32'h0080_C000 | LOW);
    output_shift_keying = 1'b0;
    repeat (3) @(negedge mclk);
    chk({30'h0, byp, prof}, 32'h0000_0002);
    repeat (8)
    begin
      @(negedge mclk);
      chk({31'h0, sclk}, 32'h0000_0000);
    end
    test_done();
  end
  initial
  begin
    #(3000 * 100);
    err_total++;
    test_done();
  end
endmodule : control_register_two_upper_tb
